/* rtl/pmsa_regs.sv */
// Overview of operation
// - 100BASE-TX full and half ability constant one
// - T4 and 10M status bits from init bits
// - Negotiation complete zero until negotiation done
// - Negotiation ability status always one
// - Link bit latches low until status read
// - Extended capability bit always one
// - Unused bits and addresses read zero
// - Local next page bit reads zero
// - Reserved advertisement bit fourteen read-only zero
// - Writable remote fault bit, resets zero
// - Ability bits writable, reset from init/one
// - Selector field fixed at 00001
// - Partner acknowledge bit from received word
// - Partner register filled from partner word
// - Multiple link fault sets, clears on read
// - Page received sets, clears on read
// - Partner next page able bit reported
// - Local next page able reads zero
// - Partner negotiation capable bit reported
// - Init ability bits captured at power-up
`include "pmsa_regs.svh"

module pmsa_regs
  import pmsa_pkg::*;
#(
  parameter int LINKS = 2
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic INIT_LOAD,
  input wire logic [15:0] INIT_WORD,
  input wire logic MGMT_RD,
  input wire logic MGMT_WR,
  input wire logic [4:0] MGMT_ADDR,
  input wire logic [15:0] MGMT_WDATA,
  output logic [15:0] MGMT_RDATA,
  input wire logic [LINKS-1:0] LINK_OK,
  input wire logic AN_DONE,
  input wire logic AN_RESTART,
  input wire logic AN_DISABLE,
  input wire logic LP_WORD_VALID,
  input wire logic [15:0] LP_WORD,
  input wire logic PAGE_RX,
  input wire logic LP_NP_ABLE,
  input wire logic LP_AN_ABLE,
  output logic [15:0] ADV_WORD,
  output logic LINK_UP
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (LINKS < 1 || LINKS > 16) begin : g_links_check
    $error("LINKS out of range");
  end

  // ---------------------------------------------------------------
  // Input grouping
  // ---------------------------------------------------------------
  pmsa_req_t req;
  pmsa_an_t an;
  assign req = '{rd: MGMT_RD, wr: MGMT_WR, addr: MGMT_ADDR,
                 wdata: MGMT_WDATA};
  assign an = '{an_done: AN_DONE, an_restart: AN_RESTART,
                an_disable: AN_DISABLE, lp_word_valid: LP_WORD_VALID,
                lp_word: LP_WORD, page_rx: PAGE_RX,
                lp_np_able: LP_NP_ABLE, lp_an_able: LP_AN_ABLE};

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  function automatic logic [4:0] ones(input logic [LINKS-1:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < LINKS; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic hit(input pmsa_req_t r, input logic [4:0] a);
    return r.rd && (r.addr == a);
  endfunction

  function automatic logic wr_hit(input pmsa_req_t r, input logic [4:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // ---------------------------------------------------------------
  // Power-up init capture
  // ---------------------------------------------------------------
  logic init_t4_ability_bit_reg;
  logic init_ten_full_ability_bit_reg;
  logic init_ten_half_ability_bit_reg;

  always_ff @(posedge CLK) begin
    if (INIT_LOAD) begin
      init_t4_ability_bit_reg <= INIT_WORD[`PMSA_INIT_T4];
    end
  end

  always_ff @(posedge CLK) begin
    if (INIT_LOAD) begin
      init_ten_full_ability_bit_reg <= INIT_WORD[`PMSA_INIT_TEN_FD];
    end
  end

  always_ff @(posedge CLK) begin
    if (INIT_LOAD) begin
      init_ten_half_ability_bit_reg <= INIT_WORD[`PMSA_INIT_TEN_HD];
    end
  end

  // ---------------------------------------------------------------
  // Status state
  // ---------------------------------------------------------------
  logic an_done_reg;
  logic link_latch_low_until_read_reg;
  logic [4:0] link_count;
  logic link_now;
  logic multi_link;
  logic rd_status;

  assign link_count = ones(LINK_OK);
  assign link_now = (link_count == `PMSA_ONE_LINK);
  assign multi_link = (link_count > `PMSA_ONE_LINK);
  assign rd_status = hit(req, `PMSA_ADDR_STATUS);

  // ---------------------------------------------------------------
  // Negotiation complete
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      an_done_reg <= 1'b0;
    end else if (an.an_restart || an.an_disable) begin
      an_done_reg <= 1'b0;
    end else if (an.an_done) begin
      an_done_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Link status latch
  // ---------------------------------------------------------------
  // Latch low: a read reloads live state, a failure wins
  always_ff @(posedge CLK) begin
    if (RST) begin
      link_latch_low_until_read_reg <= 1'b0;
    end else if (!link_now) begin
      link_latch_low_until_read_reg <= 1'b0;
    end else if (rd_status) begin
      link_latch_low_until_read_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Advertisement register
  // ---------------------------------------------------------------
  logic adv_rf_reg;
  logic [4:0] adv_ab_reg;
  logic adv_loaded_reg;
  logic adv_wr;

  assign adv_wr = wr_hit(req, `PMSA_ADDR_ADV);

  always_ff @(posedge CLK) begin
    if (RST || INIT_LOAD) begin
      adv_loaded_reg <= 1'b0;
    end else begin
      adv_loaded_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      adv_rf_reg <= 1'b0;
    end else if (adv_wr) begin
      adv_rf_reg <= req.wdata[`PMSA_ADV_RF];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || !adv_loaded_reg) begin
      adv_ab_reg <= {init_t4_ability_bit_reg, 1'b1, 1'b1,
                     init_ten_full_ability_bit_reg,
                     init_ten_half_ability_bit_reg};
    end else if (adv_wr) begin
      adv_ab_reg <= req.wdata[`PMSA_ADV_T4:`PMSA_ADV_TEN_HD];
    end
  end

  // ---------------------------------------------------------------
  // Partner register
  // ---------------------------------------------------------------
  logic [15:0] lp_reg;

  always_ff @(posedge CLK) begin
    if (an.lp_word_valid) begin
      lp_reg <= an.lp_word;
    end
  end

  // ---------------------------------------------------------------
  // Expansion register
  // ---------------------------------------------------------------
  logic mlf_reg;
  logic page_rx_reg;
  logic lp_np_reg;
  logic lp_an_reg;
  logic rd_exp;

  assign rd_exp = hit(req, `PMSA_ADDR_EXP);

  // ---------------------------------------------------------------
  // Clear-on-read flags
  // ---------------------------------------------------------------
  // Set wins over the read clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      mlf_reg <= 1'b0;
    end else if (multi_link) begin
      mlf_reg <= 1'b1;
    end else if (rd_exp) begin
      mlf_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      page_rx_reg <= 1'b0;
    end else if (an.page_rx) begin
      page_rx_reg <= 1'b1;
    end else if (rd_exp) begin
      page_rx_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Partner ability levels
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      lp_np_reg <= 1'b0;
    end else begin
      lp_np_reg <= an.lp_np_able;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      lp_an_reg <= 1'b0;
    end else begin
      lp_an_reg <= an.lp_an_able;
    end
  end

  // ---------------------------------------------------------------
  // Read word assembly
  // ---------------------------------------------------------------
  logic [15:0] status_word;
  logic [15:0] adv_word;
  logic [15:0] exp_word;
  logic [15:0] rdata_next;

  always_comb begin
    status_word = `PMSA_ZERO16;
    status_word[`PMSA_ST_T4] = init_t4_ability_bit_reg;
    status_word[`PMSA_ST_TX_FD] = 1'b1;
    status_word[`PMSA_ST_TX_HD] = 1'b1;
    status_word[`PMSA_ST_TEN_FD] = init_ten_full_ability_bit_reg;
    status_word[`PMSA_ST_TEN_HD] = init_ten_half_ability_bit_reg;
    status_word[`PMSA_ST_AN_DONE] = an_done_reg;
    status_word[`PMSA_ST_AN_ABLE] = 1'b1;
    status_word[`PMSA_ST_LINK] = link_latch_low_until_read_reg;
    status_word[`PMSA_ST_EXT] = 1'b1;
  end

  // ---------------------------------------------------------------
  // Advertisement word
  // ---------------------------------------------------------------
  always_comb begin
    adv_word = `PMSA_ZERO16;
    adv_word[`PMSA_ADV_NP] = 1'b0;
    adv_word[`PMSA_ADV_RSV] = 1'b0;
    adv_word[`PMSA_ADV_RF] = adv_rf_reg;
    adv_word[`PMSA_ADV_T4:`PMSA_ADV_TEN_HD] = adv_ab_reg;
    adv_word[`PMSA_ADV_SEL_HI:`PMSA_ADV_SEL_LO] = `PMSA_SELECTOR;
  end

  // ---------------------------------------------------------------
  // Expansion word
  // ---------------------------------------------------------------
  always_comb begin
    exp_word = `PMSA_ZERO16;
    exp_word[`PMSA_EXP_MLF] = mlf_reg;
    exp_word[`PMSA_EXP_LP_NP] = lp_np_reg;
    exp_word[`PMSA_EXP_NP_ABLE] = 1'b0;
    exp_word[`PMSA_EXP_PAGE_RX] = page_rx_reg;
    exp_word[`PMSA_EXP_LP_AN] = lp_an_reg;
  end

  // ---------------------------------------------------------------
  // Read data select
  // ---------------------------------------------------------------
  always_comb begin
    case (req.addr)
      `PMSA_ADDR_STATUS: rdata_next = status_word;
      `PMSA_ADDR_ADV: rdata_next = adv_word;
      `PMSA_ADDR_PARTNER: rdata_next = lp_reg;
      `PMSA_ADDR_EXP: rdata_next = exp_word;
      default: rdata_next = `PMSA_ZERO16;
    endcase
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      MGMT_RDATA <= `PMSA_ZERO16;
    end else if (req.rd) begin
      MGMT_RDATA <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Advertisement copy
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      ADV_WORD <= `PMSA_ZERO16;
    end else begin
      ADV_WORD <= adv_word;
    end
  end

  // ---------------------------------------------------------------
  // Link up flag
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      LINK_UP <= 1'b0;
    end else begin
      LINK_UP <= link_now;
    end
  end

endmodule

/* pkg/pmsa_regs.svh */
`ifndef PMSA_REGS_SVH
`define PMSA_REGS_SVH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define PMSA_ADDR_STATUS 5'h01
`define PMSA_ADDR_ADV 5'h04
`define PMSA_ADDR_PARTNER 5'h05
`define PMSA_ADDR_EXP 5'h06

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PMSA_ST_T4 15
`define PMSA_ST_TX_FD 14
`define PMSA_ST_TX_HD 13
`define PMSA_ST_TEN_FD 12
`define PMSA_ST_TEN_HD 11
`define PMSA_ST_AN_DONE 5
`define PMSA_ST_AN_ABLE 3
`define PMSA_ST_LINK 2
`define PMSA_ST_EXT 0
`define PMSA_ADV_NP 15
`define PMSA_ADV_RSV 14
`define PMSA_ADV_RF 13
`define PMSA_ADV_T4 9
`define PMSA_ADV_TX_FD 8
`define PMSA_ADV_TX_HD 7
`define PMSA_ADV_TEN_FD 6
`define PMSA_ADV_TEN_HD 5
`define PMSA_ADV_SEL_HI 4
`define PMSA_ADV_SEL_LO 0
`define PMSA_EXP_MLF 4
`define PMSA_EXP_LP_NP 3
`define PMSA_EXP_NP_ABLE 2
`define PMSA_EXP_PAGE_RX 1
`define PMSA_EXP_LP_AN 0

// ---------------------------------------------------------------
// Constant values
// ---------------------------------------------------------------
`define PMSA_SELECTOR 5'h01
`define PMSA_ZERO16 16'h0000
`define PMSA_INIT_T4 8
`define PMSA_INIT_TEN_FD 9
`define PMSA_INIT_TEN_HD 10
`define PMSA_ONE_LINK 5'h01

`endif

/* pkg/pmsa_pkg.sv */
package pmsa_pkg;

  // Management access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pmsa_req_t;

  // Negotiation events from the link side
  typedef struct packed {
    logic an_done;
    logic an_restart;
    logic an_disable;
    logic lp_word_valid;
    logic [15:0] lp_word;
    logic page_rx;
    logic lp_np_able;
    logic lp_an_able;
  } pmsa_an_t;

endpackage

/* sim/pmsa_properties.sv */
module pmsa_properties #(
  parameter int LINKS = 2
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic MGMT_RD,
  input wire logic MGMT_WR,
  input wire logic [4:0] MGMT_ADDR,
  input wire logic [15:0] MGMT_WDATA,
  input wire logic [15:0] MGMT_RDATA,
  input wire logic [LINKS-1:0] LINK_OK,
  input wire logic AN_RESTART,
  input wire logic LP_WORD_VALID,
  input wire logic [15:0] LP_WORD,
  input wire logic [15:0] ADV_WORD,
  input wire logic LINK_UP
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Cycles since reset release
  // ----------------------------------------
  logic [1:0] up_reg;
  always_ff @(posedge CLK) begin
    if (RST)
      up_reg <= 2'h0;
    else if (up_reg != 2'h3)
      up_reg <= up_reg + 2'h1;
  end
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  link_one_a: assert property (
    !$past(RST) |-> LINK_UP == $onehot($past(LINK_OK)))
    else $error("link flag wrong");
  adv_fixed_a: assert property (up_reg == 2'h3 |->
    ADV_WORD[15:14] == 2'h0 && ADV_WORD[12:10] == 3'h0 &&
    ADV_WORD[4:0] == 5'h01) else $error("adv fixed bits wrong");
  adv_write_a: assert property (MGMT_WR && MGMT_ADDR == 5'h04 |->
    ##2 ADV_WORD[13:5] == 9'(($past(MGMT_WDATA, 2) >> 5) & 16'h011f))
    else $error("adv write wrong");
  status_const_a: assert property (MGMT_RD && MGMT_ADDR == 5'h01 |=>
    MGMT_RDATA[14:13] == 2'h3 && MGMT_RDATA[10:6] == 5'h00 &&
    MGMT_RDATA[4:3] == 2'h1 && MGMT_RDATA[1:0] == 2'h1)
    else $error("status constants wrong");
  exp_const_a: assert property (MGMT_RD && MGMT_ADDR == 5'h06 |=>
    MGMT_RDATA[15:5] == 11'h000 && !MGMT_RDATA[2])
    else $error("exp constants wrong");
  unmapped_zero_a: assert property (MGMT_RD &&
    !(MGMT_ADDR inside {5'h01, 5'h04, 5'h05, 5'h06}) |=>
    MGMT_RDATA == 16'h0000) else $error("unmapped read not zero");
  partner_word_a: assert property (LP_WORD_VALID ##1
    (MGMT_RD && MGMT_ADDR == 5'h05 && !LP_WORD_VALID) |=>
    MGMT_RDATA == $past(LP_WORD, 2)) else $error("partner word wrong");
  restart_clear_a: assert property (AN_RESTART ##1
    (MGMT_RD && MGMT_ADDR == 5'h01) |=> !MGMT_RDATA[5])
    else $error("restart did not clear done");
endmodule

/* sim/pmsa_station.sv */
module pmsa_station (
  input wire logic clk,
  output logic mgmt_rd,
  output logic mgmt_wr,
  output logic [4:0] mgmt_addr,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Management access tasks
  // ----------------------------------------
  initial begin
    mgmt_rd = 1'b0;
    mgmt_wr = 1'b0;
    mgmt_addr = 5'h00;
    mgmt_wdata = 16'h0000;
  end
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    mgmt_rd = 1'b1;
    mgmt_addr = a;
    @(negedge clk);
    mgmt_rd = 1'b0;
    @(negedge clk);
    d = mgmt_rdata;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge clk);
    mgmt_wr = 1'b1;
    mgmt_addr = a;
    mgmt_wdata = v;
    @(negedge clk);
    mgmt_wr = 1'b0;
  endtask
endmodule

/* sim/tb_phy_mgmt_status_ability_regs.sv */
module tb_phy_mgmt_status_ability_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, init_load, an_done, an_restart, an_disable;
  logic lp_word_valid, page_rx, lp_np_able, lp_an_able;
  logic mgmt_rd, mgmt_wr, link_up;
  logic [4:0] mgmt_addr;
  logic [15:0] init_word, mgmt_wdata, mgmt_rdata, lp_word, adv_word, d;
  logic [1:0] link_ok;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  pmsa_regs #(.LINKS(2)) dut (
    .CLK(clk), .RST(rst), .INIT_LOAD(init_load), .INIT_WORD(init_word),
    .MGMT_RD(mgmt_rd), .MGMT_WR(mgmt_wr), .MGMT_ADDR(mgmt_addr),
    .MGMT_WDATA(mgmt_wdata), .MGMT_RDATA(mgmt_rdata), .LINK_OK(link_ok),
    .AN_DONE(an_done), .AN_RESTART(an_restart), .AN_DISABLE(an_disable),
    .LP_WORD_VALID(lp_word_valid), .LP_WORD(lp_word), .PAGE_RX(page_rx),
    .LP_NP_ABLE(lp_np_able), .LP_AN_ABLE(lp_an_able),
    .ADV_WORD(adv_word), .LINK_UP(link_up));
  pmsa_station p (.clk(clk), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_reg(input logic [4:0] a, input logic [15:0] e,
    input string n);
    p.rd(a, d);
    cmp(n, e, d);
  endtask
  task automatic strobe_read(ref logic s, input logic [4:0] a);
    @(negedge clk);
    s = 1'b1;
    fork
      p.rd(a, d);
      begin
        @(negedge clk);
        s = 1'b0;
      end
    join
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    {an_done, an_restart, an_disable, lp_word_valid, page_rx} = 5'h00;
    {lp_np_able, lp_an_able, link_ok, lp_word} = 20'h00000;
    rst = 1'b1;
    init_load = 1'b1;
    init_word = 16'h0500;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    init_load = 1'b0;
    repeat (2) @(negedge clk);
    check_reg(5'h01, 16'he809, "status");
    check_reg(5'h04, 16'h03a1, "adv");
    check_reg(5'h06, 16'h0000, "exp");
    link_ok = 2'h1;
    check_reg(5'h01, 16'he809, "status");
    check_reg(5'h01, 16'he80d, "status");
    link_ok = 2'h3;
    @(negedge clk);
    link_ok = 2'h1;
    check_reg(5'h01, 16'he809, "status");
    check_reg(5'h06, 16'h0010, "exp");
    check_reg(5'h06, 16'h0000, "exp");
    p.wr(5'h04, 16'hffff);
    check_reg(5'h04, 16'h23e1, "adv");
    p.wr(5'h04, 16'h0000);
    check_reg(5'h04, 16'h0001, "adv");
    p.wr(5'h01, 16'h0000);
    check_reg(5'h01, 16'he80d, "status");
    for (int a = 0; a < 32; a++) begin
      if (!(a inside {1, 4, 5, 6}))
        check_reg(5'(a), 16'h0000, "unmapped");
    end
    strobe_read(an_done, 5'h01);
    cmp("done", 16'he82d, d);
    strobe_read(an_restart, 5'h01);
    cmp("restart", 16'he80d, d);
    strobe_read(an_done, 5'h01);
    strobe_read(an_disable, 5'h01);
    cmp("disable", 16'he80d, d);
    lp_word = 16'hc5e1;
    strobe_read(lp_word_valid, 5'h05);
    cmp("partner", 16'hc5e1, d);
    lp_word = 16'h1234;
    check_reg(5'h05, 16'hc5e1, "partner");
    lp_np_able = 1'b1;
    lp_an_able = 1'b1;
    strobe_read(page_rx, 5'h06);
    cmp("exp", 16'h000b, d);
    check_reg(5'h06, 16'h0009, "exp");
    rst = 1'b1;
    init_load = 1'b1;
    init_word = 16'h0200;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    init_load = 1'b0;
    repeat (2) @(negedge clk);
    check_reg(5'h04, 16'h01c1, "adv");
    check_reg(5'h01, 16'h7009, "status");
    conclude();
  end
endmodule
bind pmsa_regs pmsa_properties #(.LINKS(LINKS)) chk (
  .CLK(CLK), .RST(RST), .MGMT_RD(MGMT_RD), .MGMT_WR(MGMT_WR),
  .MGMT_ADDR(MGMT_ADDR), .MGMT_WDATA(MGMT_WDATA), .MGMT_RDATA(MGMT_RDATA),
  .LINK_OK(LINK_OK), .AN_RESTART(AN_RESTART), .LP_WORD(LP_WORD),
  .LP_WORD_VALID(LP_WORD_VALID), .ADV_WORD(ADV_WORD), .LINK_UP(LINK_UP));
